// file: design/pbd_pkg.sv
// Behaviour
// - Pull-downs on all gates when enable low or logic supply off.
// - Normal mode, no request, no fault: pull-downs released, hold current active.
// - Driver-disabling fault or fail safe mode engages pull-downs regardless of request.
// - Request set and all half-bridge modes 00 or 11: drivers powered down, pull-downs on.
// - Passive mode: power-down in normal mode, sleep with enable low, or supply off.
// - In passive mode only the four low-side switches stay controllable.
// - Config 00 keeps low sides off; config 01 turns them all on.
// - Config 10: low sides on above overvoltage threshold; brake pin pulled low.
// - Config 11: low sides on when brake input high and overvoltage; pin pulled low.
// - Without request, config applies only when enable low or logic supply off.
// - Supply below sleep threshold in sleep forces config 10, sticky after recovery.
package pbd_pkg;
    localparam int NUM_HB = 8;
    localparam int NUM_LS = 4;
    localparam int SYNC_W = 6;
    // Passive low-side configurations
    localparam logic [1:0] CFG_OFF = 2'h0;
    localparam logic [1:0] CFG_STATIC = 2'h1;
    localparam logic [1:0] CFG_OV = 2'h2;
    localparam logic [1:0] CFG_OV_COND = 2'h3;
    // Half-bridge modes that allow power-down
    localparam logic [1:0] HB_MODE_A = 2'h0;
    localparam logic [1:0] HB_MODE_B = 2'h3;
    // Sync input bit positions
    localparam int SI_EN = 0;
    localparam int SI_LOGIC_OFF = 1;
    localparam int SI_BRAKE = 2;
    localparam int SI_OV = 3;
    localparam int SI_SLEEP_UV = 4;
    localparam int SI_SLEEP = 5;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h00;
    localparam logic STICKY_RESET = 1'b0;
    typedef enum logic [1:0] {ST_ACTIVE, ST_PASSIVE, ST_POWERDOWN} pbd_state_t;
endpackage

// file: design/pbd_sync_if.sv
`timescale 1ns/1ps
// Carries raw and synchronised input levels between top and synchroniser
interface pbd_sync_if;
    logic [pbd_pkg::SYNC_W-1:0] raw;
    logic [pbd_pkg::SYNC_W-1:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface

// file: design/pbd_sync.sv
`timescale 1ns/1ps
module pbd_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Levels
    pbd_sync_if.snk sy
);
    logic [pbd_pkg::SYNC_W-1:0] stage1_q;
    logic [pbd_pkg::SYNC_W-1:0] stage2_q;
    logic [pbd_pkg::SYNC_W-1:0] stage1_d;
    logic [pbd_pkg::SYNC_W-1:0] stage2_d;

    // Next values; first stage feeds only the second
    always_comb begin
        stage1_d = sy.raw;
        stage2_d = stage1_q;
    end

    // Two-stage register chain
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_q <= pbd_pkg::SYNC_RESET;
            stage2_q <= pbd_pkg::SYNC_RESET;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign sy.synced = stage2_q;
endmodule

// file: design/pbd_ctrl.sv
`timescale 1ns/1ps
module pbd_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Pins and supply monitors (asynchronous levels)
    input wire logic enableIn,
    input wire logic logicSupplyOff,
    input wire logic sleepMode,
    input wire logic supplyOverPassiveOv,
    input wire logic supplyBelowSleep,
    input wire logic brakeConditionInput,
    // Fault flags and mode
    input wire logic normalMode,
    input wire logic failSafeMode,
    input wire logic chargePumpUv,
    input wire logic supplyUv,
    input wire logic supplyOv,
    input wire logic thermalShutdown,
    // Configuration bits
    input wire logic passiveBridgeRequest,
    input wire logic [1:0] passiveLowSideConfig,
    input wire logic [2*pbd_pkg::NUM_HB-1:0] halfBridgeMode,
    // Gate control outputs
    output logic gatePulldownEn,
    output logic holdDischargeEn,
    output logic gateDriverPowerDown,
    output logic passiveMode,
    output logic [pbd_pkg::NUM_LS-1:0] lowSideOn,
    output logic stickyOverride,
    // Brake open-drain pin
    output logic brakePinOut,
    output logic brakePinOe_b
);
    // Raw and synchronised level bundle
    pbd_sync_if sy ();

    // Synchronised enable, high while the drivers may run
    logic sEn;
    // Synchronised logic supply below its off threshold
    logic sLogicOff;
    // Synchronised brake condition input
    logic sBrake;
    // Synchronised battery supply above the passive overvoltage level
    logic sOv;
    // Synchronised battery supply below the sleep threshold
    logic sSleepUv;
    // Synchronised sleep mode level
    logic sSleep;

    // Every half bridge in a mode that allows power-down
    logic allModesIdle;
    // Any fault that switches the gate drivers off
    logic driverFault;
    // Power-down condition in normal mode
    logic pdCond;
    // Enable low or logic supply off
    logic pinOffState;
    // Passive configuration applies to the low sides
    logic cfgEffective;
    // Configuration after the sticky override is applied
    logic [1:0] effCfg;

    // Bridge driver state
    pbd_pkg::pbd_state_t state_q;
    // Next bridge driver state
    pbd_pkg::pbd_state_t state_d;
    // Sticky low-supply override
    logic sticky_q;
    // Next sticky override
    logic sticky_d;

    // Gate pull-down resistors engaged
    logic pulldown_q;
    // Next pull-down state
    logic pulldown_d;
    // Hold discharge current active
    logic hold_q;
    // Next hold current state
    logic hold_d;
    // Low-side switch commands
    logic [pbd_pkg::NUM_LS-1:0] ls_q;
    // Next low-side switch commands
    logic [pbd_pkg::NUM_LS-1:0] ls_d;
    // Brake pin open drain pulling low
    logic brakeDrive_q;
    // Next brake pin drive
    logic brakeDrive_d;

    // True when the half-bridge mode allows power-down
    function automatic logic mode_idle(input logic [1:0] m);
        mode_idle = (m == pbd_pkg::HB_MODE_A) || (m == pbd_pkg::HB_MODE_B);
    endfunction

    // Gather the raw asynchronous levels
    assign sy.raw[pbd_pkg::SI_EN] = enableIn;
    assign sy.raw[pbd_pkg::SI_LOGIC_OFF] = logicSupplyOff;
    assign sy.raw[pbd_pkg::SI_BRAKE] = brakeConditionInput;
    assign sy.raw[pbd_pkg::SI_OV] = supplyOverPassiveOv;
    assign sy.raw[pbd_pkg::SI_SLEEP_UV] = supplyBelowSleep;
    assign sy.raw[pbd_pkg::SI_SLEEP] = sleepMode;

    pbd_sync u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sy(sy)
    );

    // Synchronised copies
    assign sEn = sy.synced[pbd_pkg::SI_EN];
    assign sLogicOff = sy.synced[pbd_pkg::SI_LOGIC_OFF];
    assign sBrake = sy.synced[pbd_pkg::SI_BRAKE];
    assign sOv = sy.synced[pbd_pkg::SI_OV];
    assign sSleepUv = sy.synced[pbd_pkg::SI_SLEEP_UV];
    assign sSleep = sy.synced[pbd_pkg::SI_SLEEP];

    // Power-down qualification over all half bridges
    always_comb begin
        allModesIdle = 1'b1;
        for (int i = 0; i < pbd_pkg::NUM_HB; i++) begin
            if (!mode_idle(halfBridgeMode[2*i +: 2])) begin
                allModesIdle = 1'b0;
            end
        end
    end

    // Condition terms
    // Faults and mode bits are used unsynchronised: they come from
    // registers of the same clock, so one edge of latency is enough
    always_comb begin
        driverFault = chargePumpUv | supplyUv | supplyOv | thermalShutdown;
        pinOffState = !sEn || sLogicOff;
        pdCond = normalMode && passiveBridgeRequest && allModesIdle;
        // Sleep qualifies passive only with enable low
        cfgEffective = pdCond || (sSleep && !sEn) || sLogicOff;
        // Without request the configuration needs the pin-off state
        if (!passiveBridgeRequest) begin
            cfgEffective = pinOffState;
        end
    end

    // Sticky low-supply override; only a reset clears it
    always_comb begin
        sticky_d = sticky_q;
        if ((sSleep || sLogicOff || !sEn) && sSleepUv) begin
            sticky_d = 1'b1;
        end
    end

    // Effective low-side configuration
    always_comb begin
        effCfg = passiveLowSideConfig;
        if (sticky_q && pinOffState) begin
            effCfg = pbd_pkg::CFG_OV;
        end
    end

    // Bridge state selection
    always_comb begin
        if (cfgEffective && pdCond) begin
            state_d = pbd_pkg::ST_POWERDOWN;
        end else if (cfgEffective) begin
            state_d = pbd_pkg::ST_PASSIVE;
        end else begin
            state_d = pbd_pkg::ST_ACTIVE;
        end
    end

    // Gate pull-down and hold current
    // Priority order: pins off, then faults, then power-down; the hold
    // current is only used when nothing asks for the resistors, and
    // both are never on together
    always_comb begin
        pulldown_d = 1'b0;
        hold_d = 1'b0;
        if (pinOffState) begin
            pulldown_d = 1'b1;
        end else if (driverFault || failSafeMode) begin
            pulldown_d = 1'b1;
        end else if (pdCond) begin
            pulldown_d = 1'b1;
        end else if (normalMode) begin
            // Resistors off, gates held low by the hold current
            hold_d = 1'b1;
        end else begin
            // Outside normal mode the safe choice is the resistors
            pulldown_d = 1'b1;
        end
    end

    // Low-side switch control in passive mode
    // Only the four low sides are ever commanded here; every other gate
    // stays on the pull-down path, so no high side can turn on
    always_comb begin
        ls_d = '0;
        brakeDrive_d = 1'b0;
        case (state_d)
            pbd_pkg::ST_PASSIVE, pbd_pkg::ST_POWERDOWN: begin
                // Other gates stay on the pull-down path
                case (effCfg)
                    pbd_pkg::CFG_OFF: begin
                        // Passive discharge only
                        ls_d = '0;
                    end
                    pbd_pkg::CFG_STATIC: begin
                        // Static brake, independent of the supply
                        ls_d = '1;
                    end
                    pbd_pkg::CFG_OV: begin
                        // Brake only while the supply is too high
                        ls_d = {pbd_pkg::NUM_LS{sOv}};
                        brakeDrive_d = 1'b1;
                    end
                    pbd_pkg::CFG_OV_COND: begin
                        // Overvoltage brake gated by the brake input
                        ls_d = {pbd_pkg::NUM_LS{sOv && sBrake}};
                        brakeDrive_d = 1'b1;
                    end
                    default: begin
                        ls_d = '0;
                    end
                endcase
            end
            default: begin
                ls_d = '0;
                brakeDrive_d = 1'b0;
            end
        endcase
    end

    // Register all control state
    // Reset lands in the safe passive state with pull-downs engaged,
    // so the gates are held off before any input is trusted
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= pbd_pkg::ST_PASSIVE;
            sticky_q <= pbd_pkg::STICKY_RESET;
            pulldown_q <= 1'b1;
            hold_q <= 1'b0;
            ls_q <= '0;
            brakeDrive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sticky_q <= sticky_d;
            pulldown_q <= pulldown_d;
            hold_q <= hold_d;
            ls_q <= ls_d;
            brakeDrive_q <= brakeDrive_d;
        end
    end

    // Gate control outputs, straight from flip-flops
    assign gatePulldownEn = pulldown_q;
    assign holdDischargeEn = hold_q;

    // State decodes; both passive states count as passive
    assign gateDriverPowerDown = (state_q == pbd_pkg::ST_POWERDOWN);
    assign passiveMode = (state_q != pbd_pkg::ST_ACTIVE);

    // Low-side commands and sticky flag
    assign lowSideOn = ls_q;
    assign stickyOverride = sticky_q;

    // Open drain only ever drives low; the board pull-up gives the high
    assign brakePinOut = 1'b0;
    assign brakePinOe_b = !brakeDrive_q;
endmodule

// file: verification/pbd_pin_model.sv
`timescale 1ns/1ps
module pbd_pin_model (
    // Open-drain pin and board pull-up
    input wire logic pinOut,
    input wire logic pinOe_b,
    output logic pinLevel
);
    // Released pin floats up, never keeps the last driven level
    assign pinLevel = pinOe_b ? 1'b1 : pinOut;
endmodule

// file: verification/pbd_ctrl_asserts.sv
`timescale 1ns/1ps
module pbd_ctrl_asserts (
    // Watched top-level ports
    input wire logic core_clk, rst_b, enableIn, logicSupplyOff, sleepMode,
    input wire logic supplyOverPassiveOv, supplyBelowSleep, brakeConditionInput,
    input wire logic normalMode, failSafeMode, chargePumpUv, supplyUv, supplyOv,
    input wire logic thermalShutdown, passiveBridgeRequest,
    input wire logic [1:0] passiveLowSideConfig,
    input wire logic [2*pbd_pkg::NUM_HB-1:0] halfBridgeMode,
    input wire logic gatePulldownEn, holdDischargeEn, gateDriverPowerDown, passiveMode,
    input wire logic [pbd_pkg::NUM_LS-1:0] lowSideOn,
    input wire logic stickyOverride, brakePinOut, brakePinOe_b
);
    logic [1:0] upQ;
    logic [3:0] s1Q, s2Q, s3Q;
    logic [1:0] cfgQ;
    logic fault, hbOk, pinOff, lsExp;
    // Synced levels are only meaningful three edges after reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) upQ <= 2'h0;
        else if (upQ != 2'h3) upQ <= upQ + 2'h1;
    end
    // Delay line matching the two-flop synchroniser plus output register
    always_ff @(posedge core_clk) begin
        s1Q <= {enableIn, logicSupplyOff, supplyOverPassiveOv, brakeConditionInput};
        s2Q <= s1Q;
        s3Q <= s2Q;
        cfgQ <= passiveLowSideConfig;
    end
    // Bridges in 01 or 10 block the power-down
    always_comb begin
        hbOk = 1'b1;
        for (int i = 0; i < pbd_pkg::NUM_HB; i++) begin
            if (^halfBridgeMode[2*i+:2]) hbOk = 1'b0;
        end
    end
    assign fault = failSafeMode | chargePumpUv | supplyUv | supplyOv | thermalShutdown;
    assign pinOff = !s3Q[3] || s3Q[2];
    assign lsExp = cfgQ == pbd_pkg::CFG_STATIC || (cfgQ[1] && s3Q[1] && (!cfgQ[0] || s3Q[0]));
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_pulldown_off: assert property (upQ == 2'h3 && pinOff |-> gatePulldownEn && passiveMode)
        else $error("pull-downs or passive flag missing with pins off");
    a_fault_pulldown: assert property ($past(fault) |-> gatePulldownEn)
        else $error("pull-downs released during a fault");
    a_active_hold: assert property (upQ == 2'h3 && !pinOff && $past(normalMode && !passiveBridgeRequest && !fault)
        |-> !gatePulldownEn && holdDischargeEn && !passiveMode && lowSideOn == 4'h0)
        else $error("active hold state wrong");
    a_power_down: assert property (upQ == 2'h3 && !pinOff && $past(normalMode && passiveBridgeRequest && hbOk && !fault)
        |-> gateDriverPowerDown && gatePulldownEn && passiveMode)
        else $error("power-down not entered");
    a_ls_config: assert property (upQ == 2'h3 && pinOff && !stickyOverride |-> lowSideOn == {4{lsExp}})
        else $error("low-side state does not follow config");
    a_brake_pin: assert property (upQ == 2'h3 && pinOff && !stickyOverride && cfgQ[1] |-> !brakePinOe_b && !brakePinOut)
        else $error("brake pin not pulled low");
    a_sticky_force: assert property (upQ == 2'h3 && pinOff && $past(stickyOverride) |-> lowSideOn == {4{s3Q[1]}})
        else $error("sticky override not acting as overvoltage brake");
    a_sticky_keep: assert property ($past(stickyOverride) |-> stickyOverride)
        else $error("sticky override cleared without reset");
endmodule
bind pbd_ctrl pbd_ctrl_asserts i_pbd_ctrl_asserts (.*);

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst_b, enableIn, logicSupplyOff, sleepMode, supplyOverPassiveOv;
    logic supplyBelowSleep, brakeConditionInput, normalMode, failSafeMode, chargePumpUv;
    logic supplyUv, supplyOv, thermalShutdown, passiveBridgeRequest;
    logic [1:0] passiveLowSideConfig;
    logic [15:0] halfBridgeMode, rnd, hb;
    logic gatePulldownEn, holdDischargeEn, gateDriverPowerDown, passiveMode;
    logic [3:0] lowSideOn;
    logic stickyOverride, brakePinOut, brakePinOe_b, pinLevel;
    int n_mismatch = 0;
    int cmp_count = 0;
    pbd_ctrl i_pbd_ctrl (.*);
    pbd_pin_model i_pbd_pin_model (.pinOut(brakePinOut), .pinOe_b(brakePinOe_b), .pinLevel(pinLevel));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic hb_ok(input logic [15:0] m);
        for (int i = 0; i < 8; i++) if (m[2*i] != m[2*i+1]) return 1'b0;
        return 1'b1;
    endfunction
    function automatic logic [3:0] exp_ls(input logic [1:0] c, input logic ov, input logic br);
        return {4{c == 2'h1 || (c[1] && ov && (!c[0] || br))}};
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Synced inputs need three edges; one spare
    task automatic settle;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic results;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Guard against a hung sequence
    initial begin
        repeat (2000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
    initial begin
        {enableIn, logicSupplyOff, sleepMode, supplyOverPassiveOv} = 4'h0;
        {supplyBelowSleep, brakeConditionInput, failSafeMode, chargePumpUv} = 4'h0;
        {supplyUv, supplyOv, thermalShutdown, passiveBridgeRequest} = 4'h0;
        normalMode = 1'b1;
        passiveLowSideConfig = 2'h0;
        halfBridgeMode = 16'h0000;
        rnd = 16'h0017;
        rst_b = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("rst pulldown", gatePulldownEn, 1'b1);
        check("rst ls", lowSideOn, 4'h0);
        @(posedge core_clk) rst_b <= 1'b1;
        // Every config with random supply and brake levels, pins off
        for (int k = 0; k < 16; k++) begin
            rnd = lfsr(rnd);
            @(posedge core_clk);
            logicSupplyOff <= rnd[4];
            passiveLowSideConfig <= k[1:0];
            supplyOverPassiveOv <= rnd[0];
            brakeConditionInput <= rnd[3];
            settle();
            check("ls cfg", lowSideOn, exp_ls(k[1:0], rnd[0], rnd[3]));
            check("pin", pinLevel, !k[1]);
            check("passive", passiveMode, 1'b1);
        end
        @(posedge core_clk);
        enableIn <= 1'b1;
        logicSupplyOff <= 1'b0;
        settle();
        check("pulldown act", gatePulldownEn, 1'b0);
        check("hold act", holdDischargeEn, 1'b1);
        check("ls act", lowSideOn, 4'h0);
        // Each driver-disabling fault on its own
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            {failSafeMode, chargePumpUv, supplyUv, supplyOv, thermalShutdown} <= 5'h1 << i;
            settle();
            check("fault pulldown", gatePulldownEn, i < 5 ? 1'b1 : 1'b0);
        end
        // Outside normal mode the gates go back to the resistors
        @(posedge core_clk);
        normalMode <= 1'b0;
        settle();
        check("pulldown idle", gatePulldownEn, 1'b1);
        check("hold idle", holdDischargeEn, 1'b0);
        @(posedge core_clk);
        normalMode <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            rnd = lfsr(rnd);
            hb = rnd & 16'h5555;
            @(posedge core_clk);
            passiveBridgeRequest <= 1'b1;
            halfBridgeMode <= k[0] ? (hb | (hb << 1)) : rnd;
            settle();
            check("powerdown", gateDriverPowerDown, hb_ok(halfBridgeMode));
            check("pd passive", passiveMode, hb_ok(halfBridgeMode));
        end
        // Sleep with enable low is passive even with the request set
        @(posedge core_clk);
        halfBridgeMode <= 16'h5555;
        {enableIn, sleepMode} <= 2'h1;
        passiveLowSideConfig <= 2'h1;
        settle();
        check("sleep passive", passiveMode, 1'b1);
        check("sleep pulldown", gatePulldownEn, 1'b1);
        check("sleep ls", lowSideOn, 4'hf);
        // Supply dip in sleep leaves a lasting overvoltage brake
        @(posedge core_clk);
        passiveBridgeRequest <= 1'b0;
        {enableIn, sleepMode, supplyOverPassiveOv, supplyBelowSleep} <= 4'h5;
        passiveLowSideConfig <= 2'h1;
        settle();
        @(posedge core_clk) supplyBelowSleep <= 1'b0;
        settle();
        check("sticky", stickyOverride, 1'b1);
        check("sticky ls", lowSideOn, 4'h0);
        @(posedge core_clk) supplyOverPassiveOv <= 1'b1;
        settle();
        check("sticky ls ov", lowSideOn, 4'hf);
        @(posedge core_clk) rst_b <= 1'b0;
        @(posedge core_clk) rst_b <= 1'b1;
        settle();
        check("sticky clr", stickyOverride, 1'b0);
        results();
    end
endmodule
